// file: ramw_alarm_match.sv
// month and weekday alarm compare with axi4-lite registers and interrupt
`timescale 1ns/1ns
module ramw_alarm_match (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [4:0] current_month,
    input wire logic [2:0] current_weekday,
    input wire logic other_fields_match,
    output logic alarm_match,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////
    // register state
    ramw_pkg::ramw_alarm_t alarm;
    ramw_pkg::ramw_calendar_t calendar;
    logic alarm_enable;
    logic [1:0] irq_mask;
    logic [1:0] irq_status;
    logic match_prev;
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;

    assign calendar.month = current_month;
    assign calendar.weekday = current_weekday;

    ////////////////////////////////////////////////////////////////////////
    // comparison
    logic month_ok;
    logic weekday_ok;
    logic month_code_valid;
    logic match_now;
    logic match_rise;

    // month compare is always active
    ramw_field_match #(
        .W(ramw_pkg::MONTH_W)
    ) u_month (
        .alarm_value(alarm.month),
        .current_value(calendar.month),
        .compare_enable(1'b1),
        .field_ok(month_ok)
    );

    // weekday only takes part while its enable bit is set
    ramw_field_match #(
        .W(ramw_pkg::WEEKDAY_W)
    ) u_weekday (
        .alarm_value(alarm.weekday),
        .current_value(calendar.weekday),
        .compare_enable(alarm.weekday_enable),
        .field_ok(weekday_ok)
    );

    // bcd month check: low nibble 0-9, tens only 0 or 1, 00000 and >12 rejected
    assign month_code_valid = (alarm.month != ramw_pkg::MONTH_INVALID)
        && (alarm.month[3:0] <= 4'h9)
        && (alarm.month <= ramw_pkg::MONTH_LAST);

    // an invalid code can never match, so no stray alarm from reset junk
    assign match_now = alarm_enable && month_code_valid && month_ok
        && weekday_ok && other_fields_match;
    // the event bit sets on entry into the match only, so a match that stands
    // for many cycles reports one event, not one per cycle
    assign match_rise = match_now && !match_prev;

    ////////////////////////////////////////////////////////////////////////
    // axi write decode
    logic wr_fire;
    logic wr_hit_month;
    logic wr_hit_weekday;
    logic wr_hit_status;
    logic wr_hit_mask;
    logic wr_hit_ctrl;
    logic wr_hit_any;
    logic [4:0] wr_month;
    logic month_write_valid;
    logic aw_take;
    logic w_take;
    logic wr_lane0;

    assign wr_fire = aw_held && w_held && !s_axi_bvalid;
    assign wr_hit_month = aw_addr == ramw_pkg::ADDR_ALARM_MONTH;
    assign wr_hit_weekday = aw_addr == ramw_pkg::ADDR_ALARM_WEEKDAY_CONTROL;
    assign wr_hit_status = aw_addr == ramw_pkg::ADDR_IRQ_STATUS;
    assign wr_hit_mask = aw_addr == ramw_pkg::ADDR_IRQ_MASK;
    assign wr_hit_ctrl = aw_addr == ramw_pkg::ADDR_ALARM_CONTROL;
    // current calendar addresses answer writes with OKAY but store nothing
    assign wr_hit_any = wr_hit_month || wr_hit_weekday || wr_hit_status
        || wr_hit_mask || wr_hit_ctrl
        || aw_addr == ramw_pkg::ADDR_CURRENT_MONTH
        || aw_addr == ramw_pkg::ADDR_CURRENT_WEEKDAY;
    assign wr_month = w_data[4:0];
    // an invalid month code is stored anyway; it raises a flag instead
    assign month_write_valid = (wr_month != ramw_pkg::MONTH_INVALID)
        && (wr_month[3:0] <= 4'h9) && (wr_month <= ramw_pkg::MONTH_LAST);

    // channel handshakes, decoded once so every process agrees on them
    assign aw_take = s_axi_awvalid && s_axi_awready;
    assign w_take = s_axi_wvalid && s_axi_wready;
    // all fields live in byte lane 0; a write without it answers but stores nothing
    assign wr_lane0 = wr_fire && w_strb[0];

    ////////////////////////////////////////////////////////////////////////
    // axi write channel capture; address and data may come in either order
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= ramw_pkg::RESP_OKAY;
        end
        else
        begin
            if (aw_take)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr[7:0];
            end
            if (w_take)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_fire)
            begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit_any ? ramw_pkg::RESP_OKAY : ramw_pkg::RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ready only while the slot is empty, so one write at a time
    // registered readies cost a cycle per transfer but keep every output a flop
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end
        else
        begin
            s_axi_awready <= !aw_held && !aw_take && !s_axi_bvalid;
            s_axi_wready <= !w_held && !w_take && !s_axi_bvalid;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // alarm registers; byte lane 0 carries all fields
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            alarm.month <= ramw_pkg::ALARM_MONTH_RESET;
            alarm.weekday_enable <= ramw_pkg::ALARM_WEEKDAY_CONTROL_RESET[7];
            alarm.weekday <= ramw_pkg::ALARM_WEEKDAY_CONTROL_RESET[2:0];
            alarm_enable <= ramw_pkg::ALARM_ENABLE_RESET;
            irq_mask <= ramw_pkg::IRQ_MASK_RESET;
        end
        else if (wr_lane0)
        begin
            if (wr_hit_month)
                alarm.month <= wr_month;
            if (wr_hit_weekday)
            begin
                // bits 6:3 have no storage, so writes there vanish
                alarm.weekday_enable <= w_data[ramw_pkg::WEEKDAY_ENABLE_BIT];
                alarm.weekday <= w_data[2:0];
            end
            if (wr_hit_mask)
                irq_mask <= w_data[1:0];
            if (wr_hit_ctrl)
                alarm_enable <= w_data[ramw_pkg::ALARM_ENABLE_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sticky status: a new event beats a write-one clear in the same cycle
    logic [1:0] irq_set;
    logic [1:0] irq_clear;
    logic [1:0] next_irq_status;

    assign irq_set[ramw_pkg::IRQ_ALARM_BIT] = match_rise;
    assign irq_set[ramw_pkg::IRQ_INVALID_BIT] = wr_lane0 && wr_hit_month
        && !month_write_valid;
    assign irq_clear = (wr_lane0 && wr_hit_status) ? w_data[1:0] : 2'h0;
    assign next_irq_status = (irq_status & ~irq_clear) | irq_set;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            irq_status <= 2'h0;
            match_prev <= 1'b0;
            alarm_match <= 1'b0;
            irq <= 1'b0;
        end
        else
        begin
            irq_status <= next_irq_status;
            match_prev <= match_now;
            alarm_match <= match_now;
            irq <= |(next_irq_status & irq_mask);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // axi read path
    logic [7:0] rd_addr;
    logic [31:0] rd_value;
    logic rd_hit;
    logic ar_take;

    assign rd_addr = s_axi_araddr[7:0];
    // read address handshake
    assign ar_take = s_axi_arvalid && s_axi_arready;
    assign rd_hit = rd_addr == ramw_pkg::ADDR_ALARM_MONTH
        || rd_addr == ramw_pkg::ADDR_ALARM_WEEKDAY_CONTROL
        || rd_addr == ramw_pkg::ADDR_CURRENT_MONTH
        || rd_addr == ramw_pkg::ADDR_CURRENT_WEEKDAY
        || rd_addr == ramw_pkg::ADDR_IRQ_STATUS
        || rd_addr == ramw_pkg::ADDR_IRQ_MASK
        || rd_addr == ramw_pkg::ADDR_ALARM_CONTROL;
    // bits 6:3 of the weekday register always read zero
    assign rd_value =
        (rd_addr == ramw_pkg::ADDR_ALARM_MONTH) ? {27'h0000000, alarm.month} :
        (rd_addr == ramw_pkg::ADDR_ALARM_WEEKDAY_CONTROL) ?
            {24'h000000, alarm.weekday_enable, 4'h0, alarm.weekday} :
        (rd_addr == ramw_pkg::ADDR_CURRENT_MONTH) ? {27'h0000000, calendar.month} :
        (rd_addr == ramw_pkg::ADDR_CURRENT_WEEKDAY) ? {29'h00000000, calendar.weekday} :
        (rd_addr == ramw_pkg::ADDR_IRQ_STATUS) ? {30'h00000000, irq_status} :
        (rd_addr == ramw_pkg::ADDR_IRQ_MASK) ? {30'h00000000, irq_mask} :
        (rd_addr == ramw_pkg::ADDR_ALARM_CONTROL) ? {31'h00000000, alarm_enable} :
        32'h00000000;

    // one read at a time; arready drops while data waits
    // rdata is captured at the handshake, so it stands while rvalid waits for rready
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= ramw_pkg::RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= !s_axi_rvalid && !ar_take;
            if (ar_take)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_value;
                s_axi_rresp <= rd_hit ? ramw_pkg::RESP_OKAY : ramw_pkg::RESP_SLVERR;
            end
            else if (s_axi_rvalid && s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule : ramw_alarm_match

// file: ramw_alarm_match_properties.sv
// concurrent checks on the ports of the month and weekday alarm block
`timescale 1ns/1ns
module ramw_alarm_match_properties (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic [4:0] current_month,
    input wire logic other_fields_match,
    input wire logic alarm_match
);
    // all checks share the bus clock; reset silences them
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire logic ar_hs = s_axi_arvalid && s_axi_arready;
    ////////////////////////////////////////////////////////////////////////
    property p_match_needs_other;
        alarm_match |-> $past(other_fields_match);
    endproperty
    a_match_needs_other: assert property (p_match_needs_other)
        else $error("alarm match without other fields matching");
    property p_match_month_valid;
        alarm_match |-> $past(current_month) != 5'h00 && $past(current_month) <= 5'h12
            && $past(current_month[3:0]) <= 4'h9;
    endproperty
    a_match_month_valid: assert property (p_match_month_valid)
        else $error("alarm match on an invalid month code");
    property p_weekday_read;
        ar_hs && s_axi_araddr[7:0] == 8'h04 |=> s_axi_rvalid && s_axi_rdata[31:3] == 29'h0
            || s_axi_rvalid && s_axi_rdata[6:3] == 4'h0 && s_axi_rdata[31:8] == 24'h0;
    endproperty
    a_weekday_read: assert property (p_weekday_read)
        else $error("weekday register unused bits read nonzero");
    property p_month_read;
        ar_hs && s_axi_araddr[7:0] == 8'h00 |=> s_axi_rvalid && s_axi_rdata[31:5] == 27'h0;
    endproperty
    a_month_read: assert property (p_month_read)
        else $error("month register wider than five bits");
    property p_write_answer;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##1 !s_axi_bvalid
            ##1 s_axi_bvalid;
    endproperty
    a_write_answer: assert property (p_write_answer)
        else $error("write response not two cycles after handshake");
    property p_unmapped_read;
        ar_hs && s_axi_araddr[7:0] > 8'h18 |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
    endproperty
    a_unmapped_read: assert property (p_unmapped_read)
        else $error("unmapped read not refused");
endmodule : ramw_alarm_match_properties

bind ramw_alarm_match ramw_alarm_match_properties i_props (.*);

// file: ramw_field_match.sv
// one alarm field comparator with enable
`timescale 1ns/1ns
module ramw_field_match #(
    parameter int W = 5
) (
    input wire logic [W-1:0] alarm_value,
    input wire logic [W-1:0] current_value,
    input wire logic compare_enable,
    output logic field_ok
);
    // a disabled field never blocks the match
    assign field_ok = !compare_enable || (alarm_value == current_value);
endmodule : ramw_field_match

// file: ramw_pkg.sv
// package for the month and weekday alarm compare block
package ramw_pkg;

    // register byte addresses (aligned words)
    localparam logic [7:0] ADDR_ALARM_MONTH = 8'h00;
    localparam logic [7:0] ADDR_ALARM_WEEKDAY_CONTROL = 8'h04;
    localparam logic [7:0] ADDR_CURRENT_MONTH = 8'h08;
    localparam logic [7:0] ADDR_CURRENT_WEEKDAY = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h10;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
    localparam logic [7:0] ADDR_ALARM_CONTROL = 8'h18;

    // field positions
    localparam int MONTH_W = 5;
    localparam int WEEKDAY_W = 3;
    localparam int WEEKDAY_ENABLE_BIT = 7;
    localparam int ALARM_ENABLE_BIT = 0;
    localparam int IRQ_ALARM_BIT = 0;
    localparam int IRQ_INVALID_BIT = 1;
    localparam int IRQ_W = 2;

    // reset values
    localparam logic [4:0] ALARM_MONTH_RESET = 5'h01;
    localparam logic [7:0] ALARM_WEEKDAY_CONTROL_RESET = 8'h00;
    localparam logic [1:0] IRQ_MASK_RESET = 2'h0;
    localparam logic ALARM_ENABLE_RESET = 1'b0;

    // month code limits
    localparam logic [4:0] MONTH_INVALID = 5'h00;
    localparam logic [4:0] MONTH_LAST = 5'h12;

    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // current calendar value presented by the counters
    typedef struct packed {
        logic [4:0] month;
        logic [2:0] weekday;
    } ramw_calendar_t;

    // alarm fields as programmed
    typedef struct packed {
        logic [4:0] month;
        logic weekday_enable;
        logic [2:0] weekday;
    } ramw_alarm_t;

endpackage : ramw_pkg

// file: tb_ramw_alarm_match.sv
// self-checking bench for the month and weekday alarm block
`timescale 1ns/1ns
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
    $display("CHECK FAILED %s expected %0h seen %0h", n, e, g); end end
module tb_ramw_alarm_match;
    typedef struct packed {
        logic [4:0] am; logic [7:0] wc; logic [4:0] cm; logic [2:0] cw; logic of; logic ex;
    } ramw_row_t;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, other, alarm_match, irq;
    logic [31:0] awaddr, wdata, araddr, rdata, d;
    logic [1:0] bresp, rresp, r;
    logic [4:0] cur_m;
    logic [2:0] cur_w;
    logic [3:0] strb;
    int miscompares = 0, n_compared = 0, cyc = 0;
    // ordinary cases: alarm fields, calendar inputs and the match they give
    ramw_row_t rows [11] = '{'{5'h12, 8'h00, 5'h12, 3'h1, 1'b1, 1'b1},
        '{5'h12, 8'h00, 5'h11, 3'h1, 1'b1, 1'b0}, '{5'h12, 8'h00, 5'h12, 3'h1, 1'b0, 1'b0},
        '{5'h09, 8'h00, 5'h09, 3'h2, 1'b1, 1'b1}, '{5'h10, 8'h00, 5'h10, 3'h2, 1'b1, 1'b1},
        '{5'h00, 8'h00, 5'h00, 3'h2, 1'b1, 1'b0}, '{5'h12, 8'h83, 5'h12, 3'h3, 1'b1, 1'b1},
        '{5'h12, 8'h83, 5'h12, 3'h4, 1'b1, 1'b0}, '{5'h12, 8'h03, 5'h12, 3'h4, 1'b1, 1'b1},
        '{5'h12, 8'h87, 5'h12, 3'h7, 1'b1, 1'b1}, '{5'h0A, 8'h00, 5'h0A, 3'h7, 1'b1, 1'b0}};
    ramw_alarm_match i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .current_month(cur_m), .current_weekday(cur_w), .other_fields_match(other),
        .alarm_match(alarm_match), .irq(irq));
    ////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        if (miscompares == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : conclude
    // address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge aclk);
        awaddr <= {24'h0, a};
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        // each valid stands until the edge at which its own ready is seen high
        while (!(aw_done && w_done))
        begin
            @(posedge aclk);
            if (!aw_done && awready === 1'b1)
            begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_done && wready === 1'b1)
            begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
        end
        while (bvalid !== 1'b1) @(posedge aclk);
        resp = bresp;
        bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
        @(posedge aclk);
        araddr <= {24'h0, a};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge aclk);
        v = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask : rd
    ////////////////////////////////////////////////////////////////////////
    // clock, and a watchdog so a stuck handshake still ends the run
    initial begin aclk = 1'b0; forever #25 aclk = ~aclk; end
    always @(posedge aclk)
    begin
        cyc++;
        if (cyc == 8000) begin miscompares++; conclude(); end
    end
    // main sequence
    initial
    begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, other} = '0;
        {awaddr, wdata, araddr, cur_m, cur_w} = '0;
        strb = 4'hF;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        `CHK("match_reset", 1'b0, alarm_match);
        rd(8'h04, d, r); `CHK("weekday_reset", 32'h0, d);
        rd(8'h00, d, r); `CHK("month_reset", 32'h1, d);
        rd(8'h40, d, r); `CHK("unmapped_read", 2'h2, r);
        wr(8'h40, 32'h1, r); `CHK("unmapped_write", 2'h2, r);
        wr(8'h04, 32'hFF, r); rd(8'h04, d, r); `CHK("weekday_unused", 32'h87, d);
        wr(8'h18, 32'h1, r);
        foreach (rows[i])
        begin
            wr(8'h00, {27'h0, rows[i].am}, r);
            wr(8'h04, {24'h0, rows[i].wc}, r);
            cur_m <= rows[i].cm;
            cur_w <= rows[i].cw;
            other <= rows[i].of;
            repeat (3) @(posedge aclk);
            `CHK("alarm_match", rows[i].ex, alarm_match);
        end
        rd(8'h08, d, r); `CHK("current_month", 32'h0A, d);
        rd(8'h0C, d, r); `CHK("current_weekday", 32'h7, d);
        // rows made match events and wrote codes 00000 and 01010
        rd(8'h10, d, r); `CHK("status_events", 32'h3, d);
        // events latched while masked only appear once unmasked
        `CHK("irq_masked", 1'b0, irq);
        wr(8'h14, 32'h3, r); repeat (2) @(posedge aclk); `CHK("irq_on", 1'b1, irq);
        wr(8'h10, 32'h3, r); repeat (2) @(posedge aclk); `CHK("irq_clear", 1'b0, irq);
        cur_m <= 5'h12;
        wr(8'h00, 32'h12, r); repeat (3) @(posedge aclk);
        `CHK("irq_event", 1'b1, irq);
        wr(8'h14, 32'h0, r); repeat (2) @(posedge aclk); `CHK("irq_mask", 1'b0, irq);
        // a write without byte lane 0 is answered but stores nothing
        strb <= 4'hE;
        wr(8'h00, 32'h05, r); `CHK("strb_resp", 2'h0, r);
        strb <= 4'hF;
        rd(8'h00, d, r); `CHK("strb_ignored", 32'h12, d);
        // a second reset in mid-run brings every programmed field back to its default
        wr(8'h04, 32'h87, r);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        `CHK("match_rereset", 1'b0, alarm_match);
        rd(8'h04, d, r); `CHK("weekday_rereset", 32'h0, d);
        rd(8'h00, d, r); `CHK("month_rereset", 32'h1, d);
        rd(8'h10, d, r); `CHK("status_rereset", 32'h0, d);
        conclude();
    end
endmodule : tb_ramw_alarm_match
